// ### design/dual_comparator_control.sv
// register file and digital control around two analog comparators
//
// Functional notes
// - two identical comparators; only 0 resets
// - latched and raw outputs, optionally pinned
// - raw output works without system clock
// - positive and negative input select fields
// - disabled comparator drives its pins low
// - result readable, interrupting, pinned together
// - mode register sets analog response time
// - two-bit hysteresis fields: off,5,10,20 mV
// - rising and falling edge interrupts separately
// - falling edge sets falling flag
// - rising edge sets rising flag
// - flags stay until software clears them
// - output state bit readable, read-only
// - enable bit 1 on, 0 off
// - comparator 0 may request system reset
// - output pins open-drain or push-pull
// - edge interrupt enables gate the request, not the flags
// - mode field bits 1:0, resets to 2
// - control bits 7..4, reset all zero
// - state bit 1 when positive above negative
`timescale 1ns/100ps
module dual_comparator_control
    import cmp_pkg::*;
(
    input wire logic clk_sys,                  // system clock
    input wire logic sys_rst,                  // sync reset, active high
    // register port
    input wire logic [7:0] regAddr,            // register address
    input wire logic [7:0] regWrData,          // write data
    input wire logic regWrStrobe,              // one-cycle write strobe
    input wire logic regRdStrobe,              // one-cycle read strobe
    output logic [7:0] regRdData,              // read data, next cycle
    // analog comparator side
    input wire logic [NUM_CMP-1:0] cmpCompare, // raw analog result
    output logic [NUM_CMP-1:0] cmpEnable,      // comparator power on
    output logic [NUM_CMP-1:0][1:0] cmpPosSel, // positive input pin
    output logic [NUM_CMP-1:0][1:0] cmpNegSel, // negative input pin
    output logic [NUM_CMP-1:0][1:0] cmpHysPos, // positive hysteresis
    output logic [NUM_CMP-1:0][1:0] cmpHysNeg, // negative hysteresis
    output logic [NUM_CMP-1:0][1:0] cmpRespMode, // response time mode
    // port pins
    output logic [NUM_CMP-1:0] latchedPinOut,  // synchronous output
    output logic [NUM_CMP-1:0] latchedPinOe,   // its output enable
    output logic [NUM_CMP-1:0] rawPinOut,      // asynchronous output
    output logic [NUM_CMP-1:0] rawPinOe,       // its output enable
    // system
    output logic [NUM_CMP-1:0] cmpIrq,         // interrupt request level
    output logic cmpResetReq                   // reset request level
);

    typedef struct packed {
        logic enable;
        hyst_t hysPos;
        hyst_t hysNeg;
        logic riseFlag;
        logic fallFlag;
        logic [1:0] posSel;
        logic [1:0] negSel;
        logic riseIrqEn;
        logic fallIrqEn;
        response_t respMode;
        logic irq;
    } cmp_state_t;

    typedef struct packed {
        cmp_state_t [NUM_CMP-1:0] cmp;
        logic [7:0] pinCfg;
        logic resetSrcEn;
        logic resetReq;
        logic [7:0] rdData;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    logic [NUM_CMP-1:0] gatedRaw;
    logic [NUM_CMP-1:0] syncLevel;
    logic [NUM_CMP-1:0] risePulse;
    logic [NUM_CMP-1:0] fallPulse;
    logic [NUM_CMP-1:0] wrCtrl;
    logic [NUM_CMP-1:0] wrMux;
    logic [NUM_CMP-1:0] wrMode;

    // per comparator: synchroniser, pin drivers and the raw path
    for (genvar g = 0; g < NUM_CMP; g++) begin : gen_cmp
        cmp_chan_if chIf ();

        // disabled comparator presents a low output everywhere
        assign gatedRaw[g] = cmpCompare[g] & state_reg.cmp[g].enable;
        assign chIf.rawIn = gatedRaw[g];
        assign syncLevel[g] = chIf.syncLevel;
        assign risePulse[g] = chIf.risePulse;
        assign fallPulse[g] = chIf.fallPulse;

        cmp_channel uChan (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .chIf(chIf.chan)
        );

        // latched output follows the synchronised level
        cmp_pin_driver uLatchPin (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .value(syncLevel[g]),
            .route(state_reg.pinCfg[PIN_LATCH_LSB + g]),
            .pushPull(state_reg.pinCfg[PIN_PP_LATCH_LSB + g]),
            .pinOut(latchedPinOut[g]),
            .pinOe(latchedPinOe[g])
        );

        // raw path has no flop so it still works with the clock stopped;
        // the route bits are static register levels, not clocked data
        assign rawPinOut[g] = state_reg.pinCfg[PIN_RAW_LSB + g]
            & gatedRaw[g];
        assign rawPinOe[g] = state_reg.pinCfg[PIN_RAW_LSB + g]
            & (state_reg.pinCfg[PIN_PP_RAW_LSB + g] | ~gatedRaw[g]);

        // write decode, one strobe per register kind
        assign wrCtrl[g] = regWrStrobe
            & (regAddr == ((g == 0) ? ADDR_CTRL0 : ADDR_CTRL1));
        assign wrMux[g] = regWrStrobe
            & (regAddr == ((g == 0) ? ADDR_MUX0 : ADDR_MUX1));
        assign wrMode[g] = regWrStrobe
            & (regAddr == ((g == 0) ? ADDR_MODE0 : ADDR_MODE1));
    end

    // control register image as software sees it
    function automatic logic [7:0] ctrlImage(input cmp_state_t c,
                                             input logic level);
        logic [7:0] v;
        v = 8'h00;
        v[CTRL_EN_BIT] = c.enable;
        v[CTRL_OUT_BIT] = level;
        v[CTRL_RISE_BIT] = c.riseFlag;
        v[CTRL_FALL_BIT] = c.fallFlag;
        v[CTRL_HYP_LSB +: 2] = c.hysPos;
        v[CTRL_HYN_LSB +: 2] = c.hysNeg;
        return v;
    endfunction : ctrlImage

    // input select image, unused bits read zero
    function automatic logic [7:0] muxImage(input cmp_state_t c);
        logic [7:0] v;
        v = 8'h00;
        v[MUX_NEG_LSB +: 2] = c.negSel;
        v[MUX_POS_LSB +: 2] = c.posSel;
        return v;
    endfunction : muxImage

    // mode image, unused bits read zero
    function automatic logic [7:0] modeImage(input cmp_state_t c);
        logic [7:0] v;
        v = 8'h00;
        v[MODE_RIE_BIT] = c.riseIrqEn;
        v[MODE_FIE_BIT] = c.fallIrqEn;
        v[MODE_MD_LSB +: 2] = c.respMode;
        return v;
    endfunction : modeImage

    // next state: register writes, sticky flags, interrupts, read data
    always_comb begin
        state_next = state_reg;
        for (int i = 0; i < NUM_CMP; i++) begin
            if (wrCtrl[i]) begin
                state_next.cmp[i].enable = regWrData[CTRL_EN_BIT];
                state_next.cmp[i].hysPos =
                    hyst_t'(regWrData[CTRL_HYP_LSB +: 2]);
                state_next.cmp[i].hysNeg =
                    hyst_t'(regWrData[CTRL_HYN_LSB +: 2]);
                // only a software write can clear a flag
                state_next.cmp[i].riseFlag = regWrData[CTRL_RISE_BIT];
                state_next.cmp[i].fallFlag = regWrData[CTRL_FALL_BIT];
            end
            if (wrMux[i]) begin
                state_next.cmp[i].posSel = regWrData[MUX_POS_LSB +: 2];
                state_next.cmp[i].negSel = regWrData[MUX_NEG_LSB +: 2];
            end
            if (wrMode[i]) begin
                state_next.cmp[i].riseIrqEn = regWrData[MODE_RIE_BIT];
                state_next.cmp[i].fallIrqEn = regWrData[MODE_FIE_BIT];
                state_next.cmp[i].respMode =
                    response_t'(regWrData[MODE_MD_LSB +: 2]);
            end
            // an edge in the clearing cycle still sets the flag
            if (risePulse[i]) begin
                state_next.cmp[i].riseFlag = 1'b1;
            end
            if (fallPulse[i]) begin
                state_next.cmp[i].fallFlag = 1'b1;
            end
            // request follows the flags as they will stand next cycle
            state_next.cmp[i].irq =
                (state_next.cmp[i].riseFlag & state_next.cmp[i].riseIrqEn)
                | (state_next.cmp[i].fallFlag
                   & state_next.cmp[i].fallIrqEn);
        end
        if (regWrStrobe && regAddr == ADDR_PINCFG) begin
            state_next.pinCfg = regWrData;
        end
        if (regWrStrobe && regAddr == ADDR_RSTSRC) begin
            state_next.resetSrcEn = regWrData[RSTSRC_EN_BIT];
        end
        // comparator 0 asks for reset while enabled and its output low
        state_next.resetReq = state_next.resetSrcEn
            & state_reg.cmp[0].enable & ~syncLevel[0];
        // read data stand for exactly the cycle after the strobe
        state_next.rdData = 8'h00;
        if (regRdStrobe) begin
            case (regAddr)
                ADDR_CTRL0: state_next.rdData =
                    ctrlImage(state_reg.cmp[0], syncLevel[0]);
                ADDR_CTRL1: state_next.rdData =
                    ctrlImage(state_reg.cmp[1], syncLevel[1]);
                ADDR_MUX0: state_next.rdData = muxImage(state_reg.cmp[0]);
                ADDR_MUX1: state_next.rdData = muxImage(state_reg.cmp[1]);
                ADDR_MODE0: state_next.rdData = modeImage(state_reg.cmp[0]);
                ADDR_MODE1: state_next.rdData = modeImage(state_reg.cmp[1]);
                ADDR_PINCFG: state_next.rdData = state_reg.pinCfg;
                ADDR_RSTSRC: state_next.rdData = {7'h00, state_reg.resetSrcEn};
                default: state_next.rdData = 8'h00;
            endcase
        end
    end

    // state register with documented reset values
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                state_reg.cmp[i].enable <= 1'b0;
                state_reg.cmp[i].hysPos <= HYST_RESET;
                state_reg.cmp[i].hysNeg <= HYST_RESET;
                state_reg.cmp[i].riseFlag <= 1'b0;
                state_reg.cmp[i].fallFlag <= 1'b0;
                state_reg.cmp[i].posSel <= SEL_RESET;
                state_reg.cmp[i].negSel <= SEL_RESET;
                state_reg.cmp[i].riseIrqEn <= 1'b0;
                state_reg.cmp[i].fallIrqEn <= 1'b0;
                state_reg.cmp[i].respMode <= RESP_RESET;
                state_reg.cmp[i].irq <= 1'b0;
            end
            state_reg.pinCfg <= PINCFG_RESET;
            state_reg.resetSrcEn <= 1'b0;
            state_reg.resetReq <= 1'b0;
            state_reg.rdData <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // analog settings and status outputs straight from the state flops
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            cmpEnable[i] = state_reg.cmp[i].enable;
            cmpPosSel[i] = state_reg.cmp[i].posSel;
            cmpNegSel[i] = state_reg.cmp[i].negSel;
            cmpHysPos[i] = state_reg.cmp[i].hysPos;
            cmpHysNeg[i] = state_reg.cmp[i].hysNeg;
            cmpRespMode[i] = state_reg.cmp[i].respMode;
            cmpIrq[i] = state_reg.cmp[i].irq;
        end
        cmpResetReq = state_reg.resetReq;
        regRdData = state_reg.rdData;
    end

endmodule : dual_comparator_control

// ### design/cmp_pkg.sv
// shared constants and types for the dual comparator control block
package cmp_pkg;

    // number of comparator instances
    localparam int NUM_CMP = 2;

    // register addresses, kept at their printed offsets
    localparam logic [7:0] ADDR_CTRL1 = 8'h9A;
    localparam logic [7:0] ADDR_CTRL0 = 8'h9B;
    localparam logic [7:0] ADDR_MODE1 = 8'h9C;
    localparam logic [7:0] ADDR_MODE0 = 8'h9D;
    localparam logic [7:0] ADDR_MUX1 = 8'h9E;
    localparam logic [7:0] ADDR_MUX0 = 8'h9F;
    // pin routing and reset source control
    localparam logic [7:0] ADDR_PINCFG = 8'hA0;
    localparam logic [7:0] ADDR_RSTSRC = 8'hA1;

    // control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;

    // input select register fields
    localparam int MUX_NEG_LSB = 4;
    localparam int MUX_POS_LSB = 0;

    // mode register fields
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_MD_LSB = 0;

    // pin configuration fields, one bit per comparator from each lsb
    localparam int PIN_LATCH_LSB = 0;
    localparam int PIN_RAW_LSB = 2;
    localparam int PIN_PP_LATCH_LSB = 4;
    localparam int PIN_PP_RAW_LSB = 6;
    localparam int RSTSRC_EN_BIT = 0;

    // synchroniser depth for the raw comparator result
    localparam int SYNC_STAGES = 2;

    // hysteresis settings
    typedef enum logic [1:0] {
        HYST_OFF = 2'b00,
        HYST_5MV = 2'b01,
        HYST_10MV = 2'b10,
        HYST_20MV = 2'b11
    } hyst_t;

    // response time modes, mode 0 fastest
    typedef enum logic [1:0] {
        RESP_MODE0 = 2'b00,
        RESP_MODE1 = 2'b01,
        RESP_MODE2 = 2'b10,
        RESP_MODE3 = 2'b11
    } response_t;

    // values after reset
    localparam hyst_t HYST_RESET = HYST_OFF;
    localparam response_t RESP_RESET = RESP_MODE2;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [7:0] PINCFG_RESET = 8'h00;

endpackage : cmp_pkg

// ### design/cmp_chan_if.sv
// signals between the control top and one comparator channel
`timescale 1ns/100ps
interface cmp_chan_if;
    logic rawIn;
    logic syncLevel;
    logic risePulse;
    logic fallPulse;

    modport chan (
        input rawIn,
        output syncLevel,
        output risePulse,
        output fallPulse
    );

    modport ctrl (
        output rawIn,
        input syncLevel,
        input risePulse,
        input fallPulse
    );
endinterface : cmp_chan_if

// ### design/cmp_channel.sv
// synchroniser and edge detector for one comparator result
`timescale 1ns/100ps
module cmp_channel
    import cmp_pkg::*;
(
    input wire logic clk_sys,   // system clock
    input wire logic sys_rst,   // synchronous reset, active high
    cmp_chan_if.chan chIf       // raw result in, level and edges out
);

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        logic prev;
        logic rise;
        logic fall;
    } chan_state_t;

    chan_state_t state_reg;
    chan_state_t state_next;

    // only the last stage is looked at; stage 0 may be metastable
    always_comb begin
        state_next = state_reg;
        state_next.sync = {state_reg.sync[SYNC_STAGES-2:0], chIf.rawIn};
        state_next.prev = state_reg.sync[SYNC_STAGES-1];
        state_next.rise = state_reg.sync[SYNC_STAGES-1] & ~state_reg.prev;
        state_next.fall = ~state_reg.sync[SYNC_STAGES-1] & state_reg.prev;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign chIf.syncLevel = state_reg.sync[SYNC_STAGES-1];
    assign chIf.risePulse = state_reg.rise;
    assign chIf.fallPulse = state_reg.fall;

endmodule : cmp_channel

// ### design/cmp_pin_driver.sv
// registered driver for a comparator output pin, open-drain or push-pull
`timescale 1ns/100ps
module cmp_pin_driver (
    input wire logic clk_sys,   // system clock
    input wire logic sys_rst,   // synchronous reset, active high
    input wire logic value,     // level to present
    input wire logic route,     // pin assigned to this output
    input wire logic pushPull,  // 1 push-pull, 0 open-drain
    output logic pinOut,        // pin output value
    output logic pinOe          // pin output enable
);

    typedef struct packed {
        logic o;
        logic oe;
    } pin_state_t;

    pin_state_t state_reg;
    pin_state_t state_next;

    // open-drain only drives while the level is low
    always_comb begin
        state_next.o = route & value;
        state_next.oe = route & (pushPull | ~value);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pinOut = state_reg.o;
    assign pinOe = state_reg.oe;

endmodule : cmp_pin_driver

// ### testbench/cmp_ctrl_properties.sv
// concurrent checks on the comparator control top ports
`timescale 1ns/100ps
module cmp_ctrl_properties
    import cmp_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic sys_rst, // reset
    input wire logic [7:0] regAddr, // address
    input wire logic [7:0] regWrData, // write data
    input wire logic regWrStrobe, // write strobe
    input wire logic regRdStrobe, // read strobe
    input wire logic [7:0] regRdData, // read data
    input wire logic [NUM_CMP-1:0] cmpCompare, // raw result
    input wire logic [NUM_CMP-1:0] cmpEnable, // power on
    input wire logic [NUM_CMP-1:0][1:0] cmpPosSel, // pos select
    input wire logic [NUM_CMP-1:0][1:0] cmpNegSel, // neg select
    input wire logic [NUM_CMP-1:0][1:0] cmpHysPos, // pos hysteresis
    input wire logic [NUM_CMP-1:0][1:0] cmpRespMode, // response
    input wire logic [NUM_CMP-1:0] rawPinOut, // raw pin
    input wire logic [NUM_CMP-1:0] rawPinOe, // raw pin enable
    input wire logic [NUM_CMP-1:0] cmpIrq, // irq
    input wire logic cmpResetReq // reset request
);
    logic riseEnable0_reg; // shadow of the rising irq enable
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // shadow kept here since the enable bit is not on a port
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            riseEnable0_reg <= 1'b0;
        end else if (regWrStrobe && regAddr == ADDR_MODE0) begin
            riseEnable0_reg <= regWrData[MODE_RIE_BIT];
        end
    end

    // a held rise seen through the two-flop synchroniser
    sequence riseSeen0;
        cmpEnable[0] && riseEnable0_reg && $rose(cmpCompare[0])
            ##1 (cmpEnable[0] && cmpCompare[0]) [*3];
    endsequence

    a_rise_raises_irq: assert property (riseSeen0 |-> ##[0:3] cmpIrq[0])
        else $error("irq missing after rise");
    a_irq_stays_set: assert property (cmpIrq[0] && !regWrStrobe |=> cmpIrq[0])
        else $error("irq dropped without write");
    a_rd_idle_zero: assert property (!$past(regRdStrobe) |-> regRdData == 8'h00)
        else $error("read data outside its slot");
    a_rd_enable_bit: assert property (regRdStrobe && regAddr == ADDR_CTRL0 |=>
        regRdData[CTRL_EN_BIT] == cmpEnable[0])
        else $error("enable bit read wrong");
    a_enable_write: assert property (regWrStrobe && regAddr == ADDR_CTRL0 |=>
        cmpEnable[0] == $past(regWrData[CTRL_EN_BIT]))
        else $error("enable not taken");
    a_resp_write: assert property (regWrStrobe && regAddr == ADDR_MODE0 |=>
        cmpRespMode[0] == $past(regWrData[1:0]))
        else $error("response mode not taken");
    a_hyst_write: assert property (regWrStrobe && regAddr == ADDR_CTRL1 |=>
        cmpHysPos[1] == $past(regWrData[3:2]))
        else $error("hysteresis not taken");
    a_mux_write: assert property (regWrStrobe && regAddr == ADDR_MUX1 |=>
        cmpPosSel[1] == $past(regWrData[1:0])
        && cmpNegSel[1] == $past(regWrData[5:4]))
        else $error("input select not taken");
    a_off_pin_low: assert property (!cmpEnable[0] |-> !rawPinOut[0])
        else $error("disabled raw pin high");
    a_raw_follows: assert property (rawPinOe[0] && cmpEnable[0] |->
        rawPinOut[0] == cmpCompare[0])
        else $error("raw pin not following");
    a_reset_needs_on: assert property (cmpResetReq |->
        cmpEnable[0] || $past(cmpEnable[0]))
        else $error("reset request while off");
endmodule : cmp_ctrl_properties

// ### testbench/analog_pin_model.sv
// analog voltages on the selectable port pins of both comparators
`timescale 1ns/100ps
module analog_pin_model
    import cmp_pkg::*;
(
    input wire logic [NUM_CMP-1:0] cmpEnable, // comparator powered
    input wire logic [NUM_CMP-1:0][1:0] cmpPosSel, // positive pin
    input wire logic [NUM_CMP-1:0][1:0] cmpNegSel, // negative pin
    input wire logic [NUM_CMP-1:0][3:0][11:0] posMv, // pin millivolts
    input wire logic [NUM_CMP-1:0][3:0][11:0] negMv, // pin millivolts
    output logic [NUM_CMP-1:0] cmpCompare // 1 when positive higher
);
    // pins stay pure analog inputs, never driven digitally; no
    // hysteresis is modelled, so keep test levels far apart
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            // a powered-down comparator rests low
            cmpCompare[i] = cmpEnable[i] &&
                (posMv[i][cmpPosSel[i]] > negMv[i][cmpNegSel[i]]);
        end
    end
endmodule : analog_pin_model

// ### testbench/tb.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/100ps
bind dual_comparator_control cmp_ctrl_properties cmp_ctrl_properties_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .cmpCompare(cmpCompare), .cmpEnable(cmpEnable),
    .cmpPosSel(cmpPosSel), .cmpNegSel(cmpNegSel), .cmpHysPos(cmpHysPos),
    .cmpRespMode(cmpRespMode), .rawPinOut(rawPinOut),
    .rawPinOe(rawPinOe), .cmpIrq(cmpIrq), .cmpResetReq(cmpResetReq));

module tb
    import cmp_pkg::*;
;
    logic clk_sys = 1'b0;
    logic clkRun = 1'b1;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    logic [7:0] regRdData;
    logic [NUM_CMP-1:0] cmpCompare, cmpEnable, latchedPinOut, latchedPinOe;
    logic [NUM_CMP-1:0] rawPinOut, rawPinOe, cmpIrq;
    logic [NUM_CMP-1:0][1:0] cmpPosSel, cmpNegSel, cmpHysPos, cmpHysNeg;
    logic [NUM_CMP-1:0][1:0] cmpRespMode;
    logic cmpResetReq;
    logic [NUM_CMP-1:0][3:0][11:0] posMv = {8{12'h1F4}};
    logic [NUM_CMP-1:0][3:0][11:0] negMv = {8{12'h3E8}};
    int errors = 0;
    int nChecks = 0;

    // clock may be parked to show the raw path needs none
    always #2 clk_sys = clkRun ? ~clk_sys : clk_sys;

    dual_comparator_control dual_comparator_control_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .cmpCompare(cmpCompare), .cmpEnable(cmpEnable),
        .cmpPosSel(cmpPosSel), .cmpNegSel(cmpNegSel),
        .cmpHysPos(cmpHysPos), .cmpHysNeg(cmpHysNeg),
        .cmpRespMode(cmpRespMode), .latchedPinOut(latchedPinOut),
        .latchedPinOe(latchedPinOe), .rawPinOut(rawPinOut),
        .rawPinOe(rawPinOe), .cmpIrq(cmpIrq), .cmpResetReq(cmpResetReq));

    analog_pin_model analog_pin_model_i (
        .cmpEnable(cmpEnable), .cmpPosSel(cmpPosSel),
        .cmpNegSel(cmpNegSel), .posMv(posMv), .negMv(negMv),
        .cmpCompare(cmpCompare));

    task automatic end_sim;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // wait edges, then step past them so registered outputs settle
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge clk_sys);
        regWrStrobe <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp,
                         input string what);
        @(posedge clk_sys);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clk_sys);
        regRdStrobe <= 1'b0;
        #1;
        chk(what, exp, regRdData);
    endtask : rdChk

    // comparator 0 positive pin 1, high or low against its negative
    task automatic drive0(input logic high);
        @(posedge clk_sys);
        posMv[0][1] <= high ? 12'h5DC : 12'h1F4;
    endtask : drive0

    task automatic t_reset;
        chk("resp0", 8'h02, {6'h00, cmpRespMode[0]});
        rdChk(ADDR_CTRL0, 8'h00, "ctrl0");
        rdChk(ADDR_CTRL1, 8'h00, "ctrl1");
        rdChk(ADDR_MODE0, 8'h02, "mode0");
        rdChk(ADDR_MODE1, 8'h02, "mode1");
        rdChk(ADDR_MUX1, 8'h00, "mux1");
        wr(8'h10, 8'hFF);
        rdChk(8'h10, 8'h00, "unmapped");
    endtask : t_reset

    task automatic t_fields;
        for (int v = 0; v < 4; v++) begin
            wr(ADDR_CTRL1, 8'(v * 5));
            wr(ADDR_MODE1, 8'(v));
            settle(1);
            chk("hyst pos", 8'(v), {6'h00, cmpHysPos[1]});
            chk("hyst neg", 8'(v), {6'h00, cmpHysNeg[1]});
            chk("resp", 8'(v), {6'h00, cmpRespMode[1]});
        end
        wr(ADDR_MUX0, 8'hFF);
        rdChk(ADDR_MUX0, 8'h33, "mux0 bits");
        wr(ADDR_MUX0, 8'h21);
        settle(1);
        chk("sel", 8'h21, {2'h0, cmpNegSel[0], 2'h0, cmpPosSel[0]});
    endtask : t_fields

    task automatic t_edges;
        wr(ADDR_MODE0, 8'h30);
        wr(ADDR_PINCFG, 8'h55);
        wr(ADDR_CTRL0, 8'h80);
        drive0(1'b1);
        settle(6);
        rdChk(ADDR_CTRL0, 8'hE0, "rise");
        chk("pins", 8'h0F, {4'h0, latchedPinOut[0], latchedPinOe[0],
            rawPinOut[0], rawPinOe[0]});
        chk("irq", 8'h01, {7'h00, cmpIrq[0]});
        drive0(1'b0);
        settle(6);
        rdChk(ADDR_CTRL0, 8'hB0, "both");
        wr(ADDR_CTRL0, 8'h80);
        settle(1);
        chk("irq clear", 8'h00, {7'h00, cmpIrq[0]});
        wr(ADDR_MODE0, 8'h10);
        drive0(1'b1);
        settle(6);
        chk("irq gated", 8'h00, {7'h00, cmpIrq[0]});
        wr(ADDR_CTRL0, 8'h00);
        settle(5);
        chk("off", 8'h00, {6'h00, rawPinOut[0], latchedPinOut[0]});
    endtask : t_edges

    task automatic t_pins;
        wr(ADDR_PINCFG, 8'h04);
        wr(ADDR_CTRL0, 8'h80);
        settle(1);
        // open-drain high: value shows 1 but the driver lets go of the pin
        chk("od high", 8'h02, {6'h00, rawPinOut[0], rawPinOe[0]});
        drive0(1'b0);
        settle(1);
        chk("od low", 8'h01, {6'h00, rawPinOut[0], rawPinOe[0]});
        wr(ADDR_PINCFG, 8'h44);
        settle(1);
        clkRun = 1'b0;
        posMv[0][1] <= 12'h5DC;
        #20;
        chk("no clock", 8'h03, {6'h00, rawPinOut[0], rawPinOe[0]});
        clkRun = 1'b1;
        settle(6);
    endtask : t_pins

    task automatic t_second;
        wr(ADDR_CTRL1, 8'h80);
        wr(ADDR_MUX1, 8'h02);
        posMv[1][2] <= 12'h5DC;
        settle(6);
        rdChk(ADDR_CTRL1, 8'hE0, "cmp1 rise");
        wr(ADDR_MUX1, 8'h00);
        settle(6);
        rdChk(ADDR_CTRL1, 8'hB0, "cmp1 fall");
        chk("cmp1 irq", 8'h00, {7'h00, cmpIrq[1]});
    endtask : t_second

    task automatic t_resetsrc;
        wr(ADDR_RSTSRC, 8'h01);
        drive0(1'b0);
        settle(6);
        chk("rst low", 8'h01, {7'h00, cmpResetReq});
        drive0(1'b1);
        settle(6);
        chk("rst high", 8'h00, {7'h00, cmpResetReq});
    endtask : t_resetsrc

    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        settle(1);
        t_reset();
        t_fields();
        t_edges();
        t_pins();
        t_second();
        t_resetsrc();
        end_sim();
    end

    // the whole run takes well under a thousand cycles
    initial begin
        #20000;
        errors++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : tb
